/* File: dram_host_pkg.sv */
// timing constants, helpers and the refresh scheduler of the dram host
`default_nettype none

package dram_host_pkg;

    // ------------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CNT_W = 12;
    localparam int TIMER_W = 20;
    typedef logic [CNT_W-1:0] count_t;

    // least time: round up, never below one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down, never below one cycle
    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // level counters hold the elapsed cycles minus one at the current edge, edge-detected ones minus two
    function automatic logic reached(input count_t cnt, input int lead,
                                     input int need);
        return (int'(cnt) + lead) >= need;
    endfunction

    function automatic count_t sat_inc(input count_t c);
        return (c == '1) ? c : c + 1'b1;
    endfunction

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int WORD_ADDR_W = 22;
    localparam int DATA_W = 4;

    function automatic logic [ADDR_W-1:0] row_of(
        input logic [WORD_ADDR_W-1:0] a);
        return a[WORD_ADDR_W-1:ADDR_W];
    endfunction

    function automatic logic [ADDR_W-1:0] col_of(
        input logic [WORD_ADDR_W-1:0] a);
        return a[ADDR_W-1:0];
    endfunction

    // ------------------------------------------------------------------
    // device times in ns and their cycle counts
    // ------------------------------------------------------------------
    localparam int RANDOM_CYCLE_MIN_NS = 110;
    localparam int RMW_CYCLE_MIN_NS = 155;
    localparam int PAGE_CYCLE_MIN_NS = 40;
    localparam int PAGE_RMW_CYCLE_MIN_NS = 85;
    localparam int ROW_ACCESS_MAX_NS = 60;
    localparam int COLUMN_ACCESS_MAX_NS = 15;
    localparam int COL_ADDRESS_ACCESS_MAX_NS = 30;
    localparam int COL_PRECHARGE_ACCESS_MAX_NS = 35;
    localparam int OUTPUT_ENABLE_ACCESS_MAX_NS = 15;
    localparam int STROBE_RELEASE_MAX_NS = 15;
    localparam int ENABLE_RELEASE_MAX_NS = 15;
    localparam int PAGE_ROW_ACTIVE_WIDTH_NS = 100000;
    localparam int ROW_PULSE_MIN_NS = 60;
    localparam int ROW_PRECHARGE_MIN_NS = 40;
    localparam int COL_PULSE_MIN_NS = 15;
    localparam int COL_PRECHARGE_MIN_NS = 10;
    localparam int COL_TO_ROW_PRECHARGE_MIN_NS = 5;
    localparam int ROW_HOLD_AFTER_COL_PRECHARGE_NS = 35;
    localparam int ROW_HOLD_AFTER_ENABLE_NS = 15;
    localparam int WRITE_TO_COL_LEAD_NS = 15;
    localparam int REFRESH_INTERVAL_MS = 32;
    localparam int REFRESH_ROWS = 2048;
    localparam int POWERUP_WAIT_US = 200;
    localparam int INIT_REFRESHES = 8;

    localparam int RANDOM_CYCLE_CYC = cyc_min(RANDOM_CYCLE_MIN_NS);
    localparam int RMW_CYCLE_CYC = cyc_min(RMW_CYCLE_MIN_NS);
    localparam int PAGE_CYCLE_CYC = cyc_min(PAGE_CYCLE_MIN_NS);
    localparam int PAGE_RMW_CYCLE_CYC = cyc_min(PAGE_RMW_CYCLE_MIN_NS);
    // latest of all access paths, measured from the column strobe fall
    localparam int ACCESS_WAIT_CYC = imax(
        imax(cyc_min(COLUMN_ACCESS_MAX_NS),
             cyc_min(OUTPUT_ENABLE_ACCESS_MAX_NS)),
        imax(cyc_min(COL_ADDRESS_ACCESS_MAX_NS) - 1,
             imax(cyc_min(ROW_ACCESS_MAX_NS) - 2,
                  cyc_min(COL_PRECHARGE_ACCESS_MAX_NS) - 1)));
    localparam int RELEASE_CYC = imax(cyc_min(STROBE_RELEASE_MAX_NS),
                                      cyc_min(ENABLE_RELEASE_MAX_NS));
    localparam int PAGE_ROW_ACTIVE_CYC = cyc_max(PAGE_ROW_ACTIVE_WIDTH_NS);
    localparam int PAGE_GUARD_CYC = 16;
    localparam int ROW_PULSE_CYC = cyc_min(ROW_PULSE_MIN_NS);
    localparam int ROW_PRECHARGE_CYC = cyc_min(ROW_PRECHARGE_MIN_NS);
    localparam int COL_PULSE_CYC = cyc_min(COL_PULSE_MIN_NS);
    localparam int COL_PRECHARGE_CYC = cyc_min(COL_PRECHARGE_MIN_NS);
    localparam int COL_TO_ROW_CYC = cyc_min(COL_TO_ROW_PRECHARGE_MIN_NS);
    localparam int ROW_HOLD_CP_CYC = cyc_min(ROW_HOLD_AFTER_COL_PRECHARGE_NS);
    localparam int ROW_HOLD_OE_CYC = cyc_min(ROW_HOLD_AFTER_ENABLE_NS);
    localparam int WRITE_LEAD_CYC = cyc_min(WRITE_TO_COL_LEAD_NS);
    localparam int REFRESH_INTERVAL_CYC =
        cyc_max(REFRESH_INTERVAL_MS * 1000000);
    localparam int POWERUP_WAIT_CYC = cyc_min(POWERUP_WAIT_US * 1000);

endpackage : dram_host_pkg

// ----------------------------------------------------------------------
// refresh scheduler: power-up wait, init refreshes, periodic demand
// ----------------------------------------------------------------------
module refresh_scheduler #(
    parameter int POWERUP_CYCLES = dram_host_pkg::POWERUP_WAIT_CYC,
    parameter int ROW_INTERVAL_CYCLES = 390
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic refresh_done,
    output logic refresh_due,
    output logic init_done
);
    localparam int TW = dram_host_pkg::TIMER_W;
    logic [TW-1:0] wait_cnt;
    logic [TW-1:0] tick_cnt;
    logic powered;
    logic [3:0] init_left;
    logic [3:0] owed;
    logic tick;

    // power-up wait, then the init refresh burst
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_cnt <= '0;
            powered <= 1'b0;
            init_left <= 4'(dram_host_pkg::INIT_REFRESHES);
            init_done <= 1'b0;
        end else begin
            if (!powered) begin
                wait_cnt <= wait_cnt + 1'b1;
                powered <= (wait_cnt == TW'(POWERUP_CYCLES - 1));
            end
            if (refresh_done && init_left != 4'h0) begin
                init_left <= init_left - 1'b1;
            end
            init_done <= powered && (init_left == 4'h0);
        end
    end

    // one row owed every interval slice; a tick beside a done is kept
    assign tick = init_done && (tick_cnt == TW'(ROW_INTERVAL_CYCLES - 1));
    always_ff @(posedge clk) begin
        if (reset) begin
            tick_cnt <= '0;
            owed <= 4'h0;
        end else begin
            tick_cnt <= (tick || !init_done) ? '0 : tick_cnt + 1'b1;
            if (tick && !(refresh_done && init_done)) begin
                owed <= (owed == 4'hF) ? owed : owed + 1'b1;
            end else if (!tick && refresh_done && init_done &&
                         owed != 4'h0) begin
                owed <= owed - 1'b1;
            end
        end
    end

    // combinational so a finished refresh is never counted twice
    assign refresh_due = (powered && init_left != 4'h0) ||
                         (owed != 4'h0);

endmodule : refresh_scheduler

`default_nettype wire

/* File: dram_host.sv */
// host controller for the 4M x 4 fast page dynamic memory
`default_nettype none
// What this block does
// - owe one refresh per 32 ms / 2048 slice and always pay it
// - refresh by column-before-row or by row-only with our counter
// - at least 110 ns between row strobe falls of random cycles
// - at least 155 ns row cycle when read-modify-write was done
// - page column strobe falls spaced 40 ns, 85 ns with modify
// - row strobe low between 60 ns and 100,000 ns in page mode
// - column strobe high at least 10 ns between page accesses
// - column strobe high at least 5 ns before a row strobe fall, except in column-before-row refresh
// - row strobe held 35 ns after the last column precharge starts
// - row strobe held 15 ns after output enable goes low
// - wait 200 us after power-up, then eight refreshes, then serve
// - write enable low before column strobe gives an early write

module dram_host #(
    parameter int POWERUP_CYCLES = dram_host_pkg::POWERUP_WAIT_CYC,
    parameter int REFRESH_INTERVAL_CYCLES =
        dram_host_pkg::REFRESH_INTERVAL_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_rmw,
    input wire logic [dram_host_pkg::WORD_ADDR_W-1:0] req_addr,
    input wire logic [dram_host_pkg::DATA_W-1:0] req_wdata,
    input wire logic refresh_row_only,
    output logic req_taken,
    output logic rsp_valid,
    output logic [dram_host_pkg::DATA_W-1:0] rsp_rdata,
    output logic init_done,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic oe_n,
    output logic [dram_host_pkg::ADDR_W-1:0] mux_address,
    output logic [dram_host_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic [dram_host_pkg::DATA_W-1:0] data_pins_in
);

    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        S_IDLE      = 9'h001,
        S_ROW       = 9'h002,
        S_COL       = 9'h004,
        S_STROBE    = 9'h008,
        S_ACCESS    = 9'h010,
        S_RMW_DRIVE = 9'h020,
        S_RMW_WRITE = 9'h040,
        S_DECIDE    = 9'h080,
        S_REF_HOLD  = 9'h100
    } state_e;

    state_e state;
    logic ref_issue;
    logic cur_write;
    logic cur_rmw;
    logic last_rmw;
    logic ref_by_row;
    logic [dram_host_pkg::ADDR_W-1:0] cur_row;
    logic [dram_host_pkg::ADDR_W-1:0] cur_col;
    logic [dram_host_pkg::DATA_W-1:0] cur_wdata;
    logic [dram_host_pkg::ADDR_W-1:0] ref_row;
    dram_host_pkg::count_t dwell;
    dram_host_pkg::count_t ras_low;
    dram_host_pkg::count_t ras_high;
    dram_host_pkg::count_t cas_high;
    dram_host_pkg::count_t row_since;
    dram_host_pkg::count_t cas_since;
    logic ras_n_q;
    logic cas_n_q;
    logic refresh_due;
    logic refresh_done;
    logic plain_write;
    logic access_done;
    logic start_ok;
    logic page_ok;
    logic close_ok;
    logic same_row;

    // ------------------------------------------------------------------
    // refresh scheduling
    // ------------------------------------------------------------------
    refresh_scheduler #(
        .POWERUP_CYCLES(POWERUP_CYCLES),
        .ROW_INTERVAL_CYCLES(REFRESH_INTERVAL_CYCLES /
                             dram_host_pkg::REFRESH_ROWS)
    ) u_refresh (
        .clk(clk),
        .reset(reset),
        .refresh_done(refresh_done),
        .refresh_due(refresh_due),
        .init_done(init_done)
    );

    // ------------------------------------------------------------------
    // strobe history counters
    // ------------------------------------------------------------------
    // ras_low, ras_high and cas_high read elapsed-minus-one, row_since and cas_since elapsed-minus-two, at the edge that checks them
    always_ff @(posedge clk) begin
        if (reset) begin
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            ras_low <= '0;
            ras_high <= '1;
            cas_high <= '1;
            row_since <= '1;
            cas_since <= '1;
        end else begin
            ras_n_q <= ras_n;
            cas_n_q <= cas_n;
            ras_low <= ras_n ? '0 : dram_host_pkg::sat_inc(ras_low);
            ras_high <= ras_n ? dram_host_pkg::sat_inc(ras_high) : '0;
            cas_high <= cas_n ? dram_host_pkg::sat_inc(cas_high) : '0;
            row_since <= (!ras_n && ras_n_q) ? '0 :
                         dram_host_pkg::sat_inc(row_since);
            cas_since <= (!cas_n && cas_n_q) ? '0 :
                         dram_host_pkg::sat_inc(cas_since);
        end
    end

    // ------------------------------------------------------------------
    // admission and close conditions
    // ------------------------------------------------------------------
    assign plain_write = cur_write && !cur_rmw;
    assign same_row = dram_host_pkg::row_of(req_addr) == cur_row;

    // the access ends once data is surely valid (or a write has landed)
    assign access_done = (state == S_ACCESS) && dram_host_pkg::reached(
        dwell, 1, plain_write ? dram_host_pkg::COL_PULSE_CYC :
                  dram_host_pkg::ACCESS_WAIT_CYC);

    // a new row strobe falls two edges after leaving idle
    assign ref_issue = refresh_due && !refresh_done;
    assign start_ok =
        dram_host_pkg::reached(row_since, 2, last_rmw ?
            dram_host_pkg::RMW_CYCLE_CYC :
            dram_host_pkg::RANDOM_CYCLE_CYC) &&
        dram_host_pkg::reached(ras_high, 2,
            dram_host_pkg::ROW_PRECHARGE_CYC) &&
        (ref_issue && !refresh_row_only ? 1'b1 :
         dram_host_pkg::reached(cas_high, 2,
            dram_host_pkg::COL_TO_ROW_CYC));

    // next column strobe would fall three edges later
    assign page_ok = req_valid && !ref_issue && same_row &&
        dram_host_pkg::reached(cas_since, 3, (cur_rmw || req_rmw) ?
            dram_host_pkg::PAGE_RMW_CYCLE_CYC :
            dram_host_pkg::PAGE_CYCLE_CYC) &&
        dram_host_pkg::reached(cas_high, 3,
            dram_host_pkg::COL_PRECHARGE_CYC) &&
        (int'(ras_low) + dram_host_pkg::PAGE_GUARD_CYC <
         dram_host_pkg::PAGE_ROW_ACTIVE_CYC);

    assign close_ok =
        dram_host_pkg::reached(ras_low, 1,
            dram_host_pkg::ROW_PULSE_CYC) &&
        dram_host_pkg::reached(cas_high, 1,
            dram_host_pkg::ROW_HOLD_CP_CYC) &&
        dram_host_pkg::reached(cas_since, 1,
            dram_host_pkg::ROW_HOLD_OE_CYC);

    // ------------------------------------------------------------------
    // sequencer driving the memory pins
    // ------------------------------------------------------------------
    // pins are flops so the device sees clean, glitch-free strobes
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= S_IDLE;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            mux_address <= '0;
            data_pins_out <= '0;
            data_pins_oe <= 1'b0;
            req_taken <= 1'b0;
            refresh_done <= 1'b0;
            cur_write <= 1'b0;
            cur_rmw <= 1'b0;
            last_rmw <= 1'b0;
            ref_by_row <= 1'b0;
            cur_row <= '0;
            cur_col <= '0;
            cur_wdata <= '0;
            ref_row <= '0;
            dwell <= '0;
        end else begin
            req_taken <= 1'b0;
            refresh_done <= 1'b0;
            dwell <= dram_host_pkg::sat_inc(dwell);
            unique case (state)
                S_IDLE: begin
                    if (start_ok && ref_issue) begin
                        ref_by_row <= refresh_row_only;
                        last_rmw <= 1'b0;
                        if (refresh_row_only) begin
                            mux_address <= ref_row;
                        end else begin
                            cas_n <= 1'b0;
                        end
                        state <= S_ROW;
                    end else if (start_ok && req_valid && init_done) begin
                        req_taken <= 1'b1;
                        cur_write <= req_write || req_rmw;
                        cur_rmw <= req_rmw;
                        last_rmw <= req_rmw;
                        cur_row <= dram_host_pkg::row_of(req_addr);
                        cur_col <= dram_host_pkg::col_of(req_addr);
                        cur_wdata <= req_wdata;
                        ref_by_row <= 1'b0;
                        mux_address <=
                            dram_host_pkg::row_of(req_addr);
                        state <= S_ROW;
                    end
                end
                S_ROW: begin
                    ras_n <= 1'b0;
                    dwell <= '0;
                    // refresh rows: column strobe already low, or row-only
                    state <= (!cas_n || ref_by_row) ? S_REF_HOLD : S_COL;
                end
                S_COL: begin
                    mux_address <= cur_col;
                    if (plain_write) begin
                        we_n <= 1'b0;
                        data_pins_out <= cur_wdata;
                        data_pins_oe <= 1'b1;
                    end
                    state <= S_STROBE;
                end
                S_STROBE: begin
                    cas_n <= 1'b0;
                    oe_n <= plain_write;
                    dwell <= '0;
                    state <= S_ACCESS;
                end
                S_ACCESS: begin
                    if (access_done) begin
                        oe_n <= 1'b1;
                        dwell <= '0;
                        if (cur_rmw) begin
                            state <= S_RMW_DRIVE;
                        end else begin
                            cas_n <= 1'b1;
                            we_n <= 1'b1;
                            data_pins_oe <= 1'b0;
                            state <= S_DECIDE;
                        end
                    end
                end
                S_RMW_DRIVE: begin
                    if (dram_host_pkg::reached(dwell, 1,
                            dram_host_pkg::RELEASE_CYC)) begin
                        data_pins_out <= cur_wdata;
                        data_pins_oe <= 1'b1;
                        we_n <= 1'b0;
                        dwell <= '0;
                        state <= S_RMW_WRITE;
                    end
                end
                S_RMW_WRITE: begin
                    if (dram_host_pkg::reached(dwell, 1,
                            dram_host_pkg::WRITE_LEAD_CYC)) begin
                        cas_n <= 1'b1;
                        we_n <= 1'b1;
                        data_pins_oe <= 1'b0;
                        state <= S_DECIDE;
                    end
                end
                S_DECIDE: begin
                    if (page_ok) begin
                        req_taken <= 1'b1;
                        cur_write <= req_write || req_rmw;
                        cur_rmw <= req_rmw;
                        last_rmw <= last_rmw || req_rmw;
                        cur_col <= dram_host_pkg::col_of(req_addr);
                        cur_wdata <= req_wdata;
                        state <= S_COL;
                    end else if (close_ok) begin
                        ras_n <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_REF_HOLD: begin
                    cas_n <= 1'b1;
                    if (dram_host_pkg::reached(ras_low, 1,
                            dram_host_pkg::ROW_PULSE_CYC)) begin
                        ras_n <= 1'b1;
                        refresh_done <= 1'b1;
                        if (ref_by_row) begin
                            ref_row <= ref_row + 1'b1;
                        end
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read response
    // ------------------------------------------------------------------
    // data pins are only sampled, never driven, while output enable is low
    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= access_done && !plain_write;
            if (access_done && !plain_write) begin
                rsp_rdata <= data_pins_in;
            end
        end
    end

endmodule : dram_host

`default_nettype wire

/* File: dram_host_props.sv */
// pin timing checker for the dram host
`default_nettype none
module dram_host_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_taken,
    input wire logic rsp_valid,
    input wire logic init_done,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic data_pins_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ----
    // strobe, bus and handshake checks
    // ----
    sequence s_open;
        $fell(ras_n);
    endsequence
    sequence s_no_reopen;
        !$fell(ras_n) ##1 !$fell(ras_n);
    endsequence
    chk_row_cycle: assert property (s_open |=> s_no_reopen)
        else $error("row reopened too soon");
    chk_row_width: assert property (s_open |=> !ras_n)
        else $error("row pulse too short");
    chk_row_close: assert property ($rose(ras_n) |-> $past(cas_n))
        else $error("row closed with column precharge short");
    chk_col_gap: assert property (
        $rose(cas_n) && !ras_n |=> cas_n)
        else $error("column precharge too short");
    chk_col_lead: assert property (
        $fell(ras_n) && cas_n |-> $past(cas_n))
        else $error("column strobe not high before row");
    chk_oe_hold: assert property ($fell(oe_n) |=> !ras_n)
        else $error("row closed right after output enable");
    chk_bus_turn: assert property (
        $rose(data_pins_oe) |-> $past(oe_n) && oe_n)
        else $error("host drives before device release");
    chk_early_write: assert property (
        $fell(cas_n) && !we_n |-> oe_n && data_pins_oe)
        else $error("early write without host data");
    chk_rsp_data: assert property (
        rsp_valid |-> !$past(cas_n) && !$past(oe_n))
        else $error("answer without an access");
    chk_init_gate: assert property (!init_done |-> !req_taken)
        else $error("request taken before init");
endmodule // dram_host_props
bind dram_host dram_host_props dram_host_props_i (.clk(clk), .reset(reset),
    .req_taken(req_taken), .rsp_valid(rsp_valid), .init_done(init_done),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .data_pins_oe(data_pins_oe));
`default_nettype wire

/* File: dram_model.sv */
// behavioural model of the 4M x 4 memory at the far side
`default_nettype none
module dram_model (
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [10:0] mux_address,
    input wire logic [3:0] data_pins_out,
    input wire logic data_pins_oe,
    output logic [3:0] data_pins_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mem [int];
    logic [10:0] row;
    logic [3:0] dq = 4'h0;
    logic drv = 1'b0;
    int a;
    time t_row = 0;
    // row latch; column-first fall is a refresh on the internal counter
    always @(negedge ras_n) if (cas_n) begin
        row = mux_address;
        t_row = $time;
    end
    // column access; write enable already low makes an early write
    always @(negedge cas_n) if (!ras_n) begin
        a = {row, mux_address};
        if (!we_n) mem[a] = data_pins_out;
    end
    // late write enable of a modify cycle; wait for the data flops to land
    always @(negedge we_n) if (!cas_n && !ras_n) begin
        #1 mem[a] = data_pins_out;
    end
    // read data only after the slowest access time
    always @(negedge cas_n, negedge oe_n) begin
        #15;
        // a column strobe soon after the row strobe waits for row access
        if ($time < t_row + 60) #(t_row + 60 - $time);
        if (!cas_n && !oe_n && we_n) begin
            dq = mem.exists(a) ? mem[a] : 4'h0;
            drv = 1'b1;
        end
    end
    always @(posedge cas_n, posedge oe_n) begin
        #15 drv = 1'b0;
    end
    // wire: contention shows unknown, released pins show the inverse
    assign data_pins_in = data_pins_oe ? (drv ? 4'hX : data_pins_out)
        : (drv ? dq : ~dq);
endmodule // dram_model
`default_nettype wire

/* File: tb_dram_host.sv */
// self-checking bench of the dram host against the memory model
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_dram_host;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, req_valid = 0, req_write = 0, req_rmw = 0;
    logic refresh_row_only = 0, req_taken, rsp_valid, init_done;
    logic ras_n, cas_n, we_n, oe_n, data_pins_oe;
    logic [21:0] req_addr = 22'h000000;
    logic [3:0] req_wdata = 4'h0, rsp_rdata, data_pins_out, data_pins_in;
    logic [3:0] exp_v;
    logic [10:0] mux_address;
    logic [3:0] shadow [int];
    logic [3:0] q [$];
    int errors = 0, checks = 0;
    always #20 clk = ~clk;
    // short power-up and a 40-cycle refresh slice keep refresh busy
    dram_host #(.POWERUP_CYCLES(50), .REFRESH_INTERVAL_CYCLES(2048 * 40))
        dram_host_i (.clk, .reset, .req_valid, .req_write, .req_rmw,
        .req_addr, .req_wdata, .refresh_row_only, .req_taken, .rsp_valid,
        .rsp_rdata, .init_done, .ras_n, .cas_n, .we_n, .oe_n, .mux_address,
        .data_pins_out, .data_pins_oe, .data_pins_in);
    dram_model dram_model_i (.ras_n, .cas_n, .we_n, .oe_n, .mux_address,
        .data_pins_out, .data_pins_oe, .data_pins_in);
    task automatic results;
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one request: 0 write, 1 read, 2 modify; held until taken
    task automatic op(input int k, input logic [21:0] a, input logic [3:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = (k == 0);
        req_rmw = (k == 2);
        req_addr = a;
        req_wdata = d;
        refresh_row_only = 1'($urandom_range(1, 0));
        if (k != 0) q.push_back(shadow.exists(a) ? shadow[a] : 4'h0);
        if (k != 1) shadow[a] = d;
        do begin
            @(negedge clk);
            n++;
        end while (req_taken !== 1'b1 && n < 4000);
        if (n >= 4000) errors++;
    endtask
    // watcher: oldest note against each answer
    always @(negedge clk) if (rsp_valid === 1'b1) begin
        // an answer with no note pending is a mismatch by itself
        if (q.size() == 0) errors++;
        exp_v = (q.size() > 0) ? q.pop_front() : 4'hX;
        `CHK("rdata", exp_v, rsp_rdata)
    end
    // two rows and eight columns so page hits and row misses both occur
    initial begin
        void'($urandom(32'hef11));
        repeat (10) @(negedge clk);
        reset = 0;
        for (int i = 0; i < 16; i++) begin
            op(0, {10'h000, i[3], 8'h00, i[2:0]}, 4'(i));
        end
        `CHK("init", 1'b1, init_done)
        for (int i = 0; i < 80; i++) begin
            op($urandom_range(2, 0), {10'h000, 1'($urandom_range(1, 0)),
                8'h00, 3'($urandom_range(7, 0))}, 4'($urandom_range(15, 0)));
        end
        req_valid = 1'b0;
        repeat (20) @(negedge clk);
        `CHK("pending", 0, q.size())
        results();
    end
    // watchdog well beyond the expected run
    initial begin
        #(40 * 30000);
        errors++;
        results();
    end
endmodule // tb_dram_host
`default_nettype wire
